//--- rtl/bank_literal_pkg.sv
// Package for the bank select and working literal-move decoder
package bank_literal_pkg;
  localparam logic [7:0] OP_LOW_BANK = 8'hb8;
  localparam logic [6:0] OP_HIGH_BANK = 7'h5d;
  localparam logic [7:0] OP_WORK_LIT = 8'hb0;
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam int LOW_LIT_LSB = 0;
  localparam int HIGH_LIT_LSB = 4;
  localparam int NIB_W = 4;
  localparam int WORD_W = 16;
  localparam int DATA_W = 8;
  // Instruction cycle phase one-hot codes
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } phase_e;
endpackage

//--- rtl/bank_select_literal_moves.sv
// Literal-move decoder/executor for bank select and working registers
// Functional notes
// - Upper byte b8 decodes load_low_bank_nibble; literal bits 3:0, bits 7:4 unused.
// - load_low_bank_nibble writes literal into bank_select_reg bits 3:0.
// - load_low_bank_nibble keeps bank_select_reg bits 7:4 unchanged.
// - Reduced variant reads upper bank nibble as zero.
// - Upper seven bits 1011101 decode load_high_bank_nibble; literal bits 7:4.
// - load_high_bank_nibble writes literal into bank_select_reg bits 7:4.
// - load_high_bank_nibble keeps bank_select_reg bits 3:0 unchanged.
// - Reduced variant does not execute load_high_bank_nibble.
// - Upper byte b0 decodes load_working_literal; low byte goes to working_reg.
// - Low bank literal is zero to fifteen, placed in low four bits.
`timescale 1ns/1ns
module bank_select_literal_moves
  import bank_literal_pkg::*;
#(
  parameter bit REDUCED = 1'b0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Instruction from fetch stage
  input wire logic i_valid,
  input wire logic [bank_literal_pkg::WORD_W-1:0] i_instr,
  // Register file view
  output logic [bank_literal_pkg::DATA_W-1:0] o_bank_select,
  output logic [bank_literal_pkg::DATA_W-1:0] o_working,
  output logic [3:0] o_phase,
  output logic o_flags_we
);
  import bank_literal_pkg::*;

  phase_e phase_q, phase_d;
  logic [WORD_W-1:0] instr_q;
  logic [DATA_W-1:0] lit_q;
  logic [DATA_W-1:0] bank_q, bank_d;
  logic [DATA_W-1:0] work_q, work_d;
  logic [2:0] kind_q;

  // Decode from held word; ignored bits never inspected
  wire logic is_low = (instr_q[15:8] == OP_LOW_BANK);
  wire logic is_high = (instr_q[15:9] == OP_HIGH_BANK) && !REDUCED;
  wire logic is_work = (instr_q[15:8] == OP_WORK_LIT);
  wire logic [NIB_W-1:0] low_lit = instr_q[LOW_LIT_LSB +: NIB_W];
  wire logic [NIB_W-1:0] high_lit = instr_q[HIGH_LIT_LSB +: NIB_W];
  wire logic [DATA_W-1:0] q2_lit = is_low ? {4'h0, low_lit} :
                                   is_high ? {high_lit, 4'h0} : instr_q[7:0];
  wire logic wr_en = (phase_q == PH_Q4);
  wire logic [NIB_W-1:0] bank_hi_keep = REDUCED ? 4'h0 : bank_q[7:4];

  always_comb begin
    case (phase_q)
      PH_Q1: phase_d = PH_Q2;
      PH_Q2: phase_d = PH_Q3;
      PH_Q3: phase_d = PH_Q4;
      PH_Q4: phase_d = PH_Q1;
      default: phase_d = PH_Q1;
    endcase
  end

  always_comb begin
    bank_d = {bank_hi_keep, bank_q[3:0]};
    work_d = work_q;
    if (wr_en && kind_q[0]) begin
      bank_d = {bank_hi_keep, lit_q[3:0]};
    end else if (wr_en && kind_q[1]) begin
      bank_d = {lit_q[7:4], bank_q[3:0]};
    end else if (wr_en && kind_q[2]) begin
      work_d = lit_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_q <= PH_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  // Word captured in Q1, literal read in Q2
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      instr_q <= '0;
      lit_q <= '0;
      kind_q <= '0;
    end else if (phase_q == PH_Q1) begin
      instr_q <= i_valid ? i_instr : '0;
      kind_q <= '0;
    end else if (phase_q == PH_Q2) begin
      lit_q <= q2_lit;
      kind_q <= {is_work, is_high, is_low};
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bank_q <= BANK_RESET;
      work_q <= WORK_RESET;
    end else begin
      bank_q <= bank_d;
      work_q <= work_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_bank_select <= BANK_RESET;
      o_working <= WORK_RESET;
      o_phase <= 4'h1;
      o_flags_we <= 1'b0;
    end else begin
      o_bank_select <= bank_d;
      o_working <= work_d;
      o_phase <= phase_d;
      o_flags_we <= 1'b0;
    end
  end

  // Assertions
  low_keeps_hi_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (wr_en && kind_q[0]) |=> bank_q[7:4] == $past(bank_hi_keep))
    else $error("low nibble load changed upper nibble");

  low_writes_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (phase_q == PH_Q1 && i_valid && i_instr[15:8] == OP_LOW_BANK)
    |=> ##3 bank_q[3:0] == $past(i_instr[3:0], 4))
    else $error("low nibble load wrong value");

  high_writes_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (phase_q == PH_Q1 && i_valid && i_instr[15:9] == OP_HIGH_BANK && !REDUCED)
    |=> ##3 bank_q[7:4] == $past(i_instr[7:4], 4))
    else $error("high nibble load wrong value");

  high_keeps_lo_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (wr_en && kind_q[1]) |=> bank_q[3:0] == $past(bank_q[3:0]))
    else $error("high nibble load changed lower nibble");

  work_writes_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (phase_q == PH_Q1 && i_valid && i_instr[15:8] == OP_WORK_LIT)
    |=> ##3 work_q == $past(i_instr[7:0], 4))
    else $error("working literal load wrong value");

  reduced_hi_zero_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    REDUCED |-> ##1 o_bank_select[7:4] == 4'h0)
    else $error("reduced variant upper nibble not zero");

  write_only_q4_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (phase_q != PH_Q4) |=> $stable(bank_q[3:0]) && $stable(work_q))
    else $error("destination written outside Q4");

  no_flags_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ##1 !o_flags_we)
    else $error("status flags touched");

  dont_care_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (phase_q == PH_Q2 && instr_q[15:9] == OP_HIGH_BANK && !REDUCED)
    |=> kind_q == 3'h2)
    else $error("don't-care bit altered decode");

  output_tracks_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_working == work_q && o_phase == phase_q)
    else $error("output copy out of step");

  bank_out_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_bank_select == bank_q)
    else $error("bank output out of step");

  bank_keeps_work_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (wr_en && (kind_q[0] || kind_q[1])) |=> $stable(work_q))
    else $error("bank load changed working value");

  work_keeps_bank_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (wr_en && kind_q[2]) |=> $stable(bank_q))
    else $error("working load changed bank value");

  other_op_idle_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (phase_q == PH_Q2 && !is_low && !is_high && !is_work) |=> kind_q == 3'h0)
    else $error("foreign opcode decoded as move");

  kind_onehot_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $onehot0(kind_q))
    else $error("more than one move decoded");

  phase_onehot_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $onehot(phase_q))
    else $error("phase not one-hot");

  phase_step_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (phase_q == PH_Q4) |=> phase_q == PH_Q1)
    else $error("phase did not wrap after Q4");

  low_lit_range_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (phase_q == PH_Q3 && kind_q[0]) |-> lit_q[7:4] == 4'h0)
    else $error("low bank literal out of range");

  high_lit_place_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (phase_q == PH_Q3 && kind_q[1]) |-> lit_q[3:0] == 4'h0)
    else $error("high bank literal misplaced");

  reduced_no_high_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (REDUCED && phase_q == PH_Q2) |=> !kind_q[1])
    else $error("reduced variant decoded high load");

  low_dont_care_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (phase_q == PH_Q2 && instr_q[15:8] == OP_LOW_BANK) |=> kind_q == 3'h1)
    else $error("unused bits altered low decode");

  invalid_nop_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (phase_q == PH_Q1 && !i_valid) |=> instr_q == '0)
    else $error("absent word not treated as no action");

  low_cov_c: cover property (@(posedge i_clk) disable iff (!i_rstn) wr_en && kind_q[0]);
  high_cov_c: cover property (@(posedge i_clk) disable iff (!i_rstn) wr_en && kind_q[1]);
  work_cov_c: cover property (@(posedge i_clk) disable iff (!i_rstn) wr_en && kind_q[2]);
  back_cov_c: cover property (@(posedge i_clk) disable iff (!i_rstn)
    (wr_en && kind_q[0]) ##4 (wr_en && kind_q[1]));
endmodule

//--- verification/fetch_model.sv
// Fetch stage model presenting instruction words at Q1
`timescale 1ns/1ns
module fetch_model
  import bank_literal_pkg::*;
(
  // Request from bench; phase from decoder
  input wire logic i_req,
  input wire logic i_dirty,
  input wire logic [15:0] i_word,
  input wire logic [3:0] i_phase,
  // Toward decoder
  output logic o_valid,
  output logic [15:0] o_instr
);
  logic [15:0] clean;
  logic in_q1;
  assign clean = (i_word[15:8] == OP_LOW_BANK) ? {i_word[15:4] & 12'hff0, i_word[3:0]} :
    (i_word[15:9] == OP_HIGH_BANK) ? {i_word[15:4], 4'h0} : i_word;
  assign in_q1 = (i_phase == PH_Q1);
  assign o_valid = i_req & in_q1;
  // Word lines show the inverse outside Q1
  assign o_instr = in_q1 ? (i_dirty ? i_word : clean) : ~clean;
endmodule

//--- verification/bank_select_literal_moves_tb.sv
// Self-checking bench for the literal-move decoder
`timescale 1ns/1ns
module bank_select_literal_moves_tb;
  import bank_literal_pkg::*;
  logic i_clk, i_rstn, req, dirty, valid, o_flags_we;
  logic [15:0] word, instr;
  logic [7:0] o_bank_select, o_working, bank_exp, work_exp;
  logic [3:0] o_phase, ph_prev;
  logic [7:0] o_bank_red, o_working_red;
  logic [15:0] exp_q[$];
  logic [7:0] ops[4] = '{8'hb8, 8'hba, 8'hbb, 8'hb0};
  int n_fail, tests_run, seed, r;
  bank_select_literal_moves uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_valid(valid),
    .i_instr(instr), .o_bank_select(o_bank_select), .o_working(o_working),
    .o_phase(o_phase), .o_flags_we(o_flags_we));
  bank_select_literal_moves #(.REDUCED(1'b1)) uut_red (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_valid(valid), .i_instr(instr), .o_bank_select(o_bank_red),
    .o_working(o_working_red), .o_phase(), .o_flags_we());
  fetch_model fetch (.i_req(req), .i_dirty(dirty), .i_word(word), .i_phase(o_phase),
    .o_valid(valid), .o_instr(instr));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic issue(input logic [15:0] w, input logic d);
    do @(negedge i_clk); while (o_phase !== PH_Q1);
    word = w;
    dirty = d;
    req = 1'b1;
    if (w[15:8] == OP_LOW_BANK) bank_exp[3:0] = w[3:0];
    else if (w[15:9] == OP_HIGH_BANK) bank_exp[7:4] = w[7:4];
    else if (w[15:8] == OP_WORK_LIT) work_exp = w[7:0];
    @(negedge i_clk);
    req = 1'b0;
    exp_q.push_back({bank_exp, work_exp});
  endtask
  // Result of each instruction is visible at the following Q1
  always @(negedge i_clk) begin
    if (i_rstn && o_phase === PH_Q1 && exp_q.size() > 0) begin
      check(o_bank_select, exp_q[0][15:8]);
      check(o_working, exp_q[0][7:0]);
      check({7'h00, o_flags_we}, 8'h00);
      check(o_bank_red, {4'h0, exp_q[0][11:8]});
      check(o_working_red, exp_q[0][7:0]);
      void'(exp_q.pop_front());
    end
  end
  // Phase walks Q1..Q4 one step per clock
  always @(negedge i_clk) begin
    if (i_rstn && ph_prev !== 4'h0) begin
      check({4'h0, o_phase}, {4'h0, ph_prev[2:0], ph_prev[3]});
    end
    ph_prev = o_phase;
  end
  initial begin
    ph_prev = 4'h0;
    seed = 94;
    i_rstn = 1'b0;
    req = 1'b0;
    dirty = 1'b0;
    word = 16'h0000;
    bank_exp = BANK_RESET;
    work_exp = WORK_RESET;
    exp_q.push_back({BANK_RESET, WORK_RESET});
    repeat (2) @(negedge i_clk);
    i_rstn <= 1'b1;
    issue(16'hb802, 1'b0);
    issue(16'hba20, 1'b0);
    issue(16'hb805, 1'b0);
    issue(16'hbb50, 1'b0);
    issue(16'hb05a, 1'b0);
    issue(16'hb7ff, 1'b0);
    issue(16'hb80f, 1'b0);
    $display("Directed moves done");
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      issue({ops[r[17:16]], r[7:0]}, 1'b1);
    end
    $display("Random moves done");
    repeat (8) @(negedge i_clk);
    complete_run();
  end
  // About 35 instruction cycles expected; allow far more
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
endmodule
